/* File: sim/bme_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Host end of the serial monitor wire
// ****************************************
module bme_host (
    // Clock
    input  wire logic        clk_i,
    // Device drive and host drive
    input  wire logic        dev_pin_i,
    input  wire logic        dev_oe_i,
    input  wire logic        host_low_i,
    // Resolved wire and last low stretch
    output wire logic        line_o,
    output var  logic [15:0] low_len_o = 16'h0000
);
    logic [15:0] run_ff = 16'h0000;
    // Wired-OR: either side only pulls low, pull-up gives the high
    assign line_o = !((dev_oe_i && !dev_pin_i) || host_low_i);
    // Time each low stretch
    always @(posedge clk_i) begin
        if (!line_o) begin
            run_ff <= run_ff + 16'h0001;
        end else begin
            if (run_ff != 16'h0000) begin
                low_len_o <= run_ff;
            end
            run_ff <= 16'h0000;
        end
    end
endmodule // bme_host
`default_nettype wire

/* File: sim/bme_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bme_consts.vh"
// ****************************************
// Break unit port checker
// ****************************************
module bme_checker (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    // Break path
    input wire logic        break_end_i,
    input wire logic        breakpoint_signal_o,
    input wire logic [15:0] break_vector_o,
    input wire logic        counter_module_halt_o,
    input wire logic        flag_clear_allow_o,
    // Monitor side
    input wire logic        security_done_i,
    input wire logic        debug_firmware_mode_o,
    input wire logic        forced_monitor_o,
    input wire logic        internal_osc_sel_o,
    input wire logic [8:0]  baud_div_o,
    input wire logic        monitor_serial_pin_o,
    input wire logic        monitor_serial_pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // New bus request; acceptable break request
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_sec;
        security_done_i && debug_firmware_mode_o && !monitor_serial_pin_oe_o;
    endsequence
    a_ack_answer: assert property (s_req |=> ack_o)
        else $error("ack late");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    a_halt_breakpoint_signal: assert property (
        breakpoint_signal_o |-> counter_module_halt_o)
        else $error("no halt");
    a_halt_end: assert property (
        counter_module_halt_o && break_end_i |=> !counter_module_halt_o)
        else $error("halt kept");
    a_vec_mode: assert property (breakpoint_signal_o |->
        break_vector_o == (debug_firmware_mode_o ? `BME_VEC_MON
                                                 : `BME_VEC_USER))
        else $error("bad vector");
    a_flag_free: assert property (
        !counter_module_halt_o |-> flag_clear_allow_o)
        else $error("flags blocked");
    a_baud_div: assert property (
        $stable(internal_osc_sel_o) ##1 $stable(internal_osc_sel_o) |->
        baud_div_o == (internal_osc_sel_o ? 9'h14f : 9'h100))
        else $error("bad divider");
    a_int_osc_blank: assert property (
        internal_osc_sel_o |-> forced_monitor_o && debug_firmware_mode_o)
        else $error("bad int osc");
    a_line_low: assert property (
        monitor_serial_pin_oe_o |-> !monitor_serial_pin_o)
        else $error("pin high");
    a_break_start: assert property (s_sec |-> ##2 monitor_serial_pin_oe_o)
        else $error("break late");
endmodule // bme_checker

bind bme_top bme_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .break_end_i(break_end_i),
    .breakpoint_signal_o(breakpoint_signal_o),
    .break_vector_o(break_vector_o),
    .counter_module_halt_o(counter_module_halt_o),
    .flag_clear_allow_o(flag_clear_allow_o),
    .security_done_i(security_done_i),
    .debug_firmware_mode_o(debug_firmware_mode_o),
    .forced_monitor_o(forced_monitor_o),
    .internal_osc_sel_o(internal_osc_sel_o), .baud_div_o(baud_div_o),
    .monitor_serial_pin_o(monitor_serial_pin_o),
    .monitor_serial_pin_oe_o(monitor_serial_pin_oe_o));
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bme_consts.vh"
// ****************************************
// Break and monitor entry bench
// ****************************************
module tb_top;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, vld = 1'h0;
    logic        done = 1'h0, bend = 1'h0, wt = 1'h0, stp = 1'h0;
    logic        irq = 1'h1, tv = 1'h0, ms1 = 1'h0, ms2 = 1'h0;
    logic        sec = 1'h0, rstn = 1'h1, hl = 1'h0, line, pin, oe;
    logic        ack, irq_o, breakpoint_signal, halt, wdog, fca, mode, frc, iosc;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic [15:0] ca = 16'h0, vec = 16'h1234, ln, bvec, a;
    logic [8:0]  div;
    logic [7:0]  msk [6] = '{8'h0, 8'hff, 8'hff, 8'h01, 8'h00, 8'h80};
    int          miscompares = 0, comparisons = 0, cycles = 0;

    bme_top i_bme_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack), .irq_o(irq_o), .cpu_addr_i(ca),
        .cpu_addr_vld_i(vld), .cpu_opcode_i(1'h1), .instr_done_i(done),
        .break_end_i(bend), .wait_mode_i(wt), .stop_mode_i(stp),
        .vec_high_i(vec[15:8]), .vec_low_i(vec[7:0]),
        .int_reset_n_i(rstn), .test_high_voltage_i(tv), .irq_pin_i(irq),
        .reset_pin_i(1'h1), .monitor_serial_pin_i(line),
        .mode_select_one_i(ms1), .mode_select_two_i(ms2),
        .security_done_i(sec), .breakpoint_signal_o(breakpoint_signal),
        .break_vector_o(bvec), .counter_module_halt_o(halt),
        .watchdog_timer_off_o(wdog), .flag_clear_allow_o(fca),
        .debug_firmware_mode_o(mode), .forced_monitor_o(frc),
        .internal_osc_sel_o(iosc), .baud_div_o(div),
        .monitor_serial_pin_o(pin), .monitor_serial_pin_oe_o(oe));
    bme_host i_bme_host (.clk_i(clk_i), .dev_pin_i(pin), .dev_oe_i(oe),
        .host_low_i(hl), .line_o(line), .low_len_o(ln));

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle, released after ack
    task automatic wb(input logic w, input logic [4:0] ad,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= ad;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = dat_o;
        if (n >= 20) miscompares++;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic fire(input logic e);
        @(posedge clk_i);
        vld <= 1'h0;
        done <= 1'h0;
        @(posedge clk_i);
        chk(breakpoint_signal, e);
        chk(halt, e);
    endtask
    task automatic hit(input logic [15:0] h, input logic w, s, e);
        ca <= h;
        wt <= w;
        stp <= s;
        vld <= 1'h1;
        fire(e);
        wt <= 1'h0;
        stp <= 1'h0;
    endtask
    // Forced break, w = wait mode
    task automatic sw(input logic w);
        wt <= w;
        wb(1, `BME_OFS_STAT_CTRL, 8'h40, rd);
        done <= 1'h1;
        fire(1'h1);
        wt <= 1'h0;
    endtask
    task automatic end_brk;
        wb(1, `BME_OFS_STAT_CTRL, 8'h00, rd);
        bend <= 1'h1;
        @(posedge clk_i);
        bend <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk(halt, 1'h0);
    endtask
    function automatic logic [2:0] exp_mode(input logic b, t, q, ok);
        if (!b)
            return (t && ok) ? 3'h4 : 3'h0;
        return q ? 3'h6 : 3'h7;
    endfunction
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] p;
        logic [2:0]  e;
        logic        b, t, q, m1, m2, h;
        void'($urandom(32'h02b79db3));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            wb(0, (i == 6) ? 5'h02 : 5'(i * 4), 8'h00, rd);
            chk(rd, 32'h0);
        end
        for (int i = 1; i < 6; i++) begin
            p = $urandom;
            wb(1, 5'(i * 4), p[7:0], rd);
            wb(0, 5'(i * 4), 8'h00, rd);
            chk(rd, {24'h0, p[7:0] & msk[i]});
        end
        $display("registers done");
        a = 16'($urandom);
        wb(1, `BME_OFS_ADDR_HIGH, a[15:8], rd);
        wb(1, `BME_OFS_ADDR_LOW, a[7:0], rd);
        wb(1, `BME_OFS_IRQ_MASK, 8'h01, rd);
        wb(1, `BME_OFS_FLAG_CTRL, 8'h80, rd);
        wb(1, `BME_OFS_AUX, 8'h01, rd);
        wb(1, `BME_OFS_STAT_CTRL, 8'h80, rd);
        hit(a, 1'h1, 1'h0, 1'h0);
        hit(a, 1'h0, 1'h1, 1'h0);
        hit(a ^ 16'h0100, 1'h0, 1'h0, 1'h0);
        hit(a, 1'h0, 1'h0, 1'h1);
        wb(0, `BME_OFS_STAT_CTRL, 8'h00, rd);
        chk(rd, 32'hc0);
        chk(irq_o, 1'h1);
        chk(fca, 1'h1);
        chk(wdog, 1'h0);
        chk(bvec, `BME_VEC_USER);
        wb(1, `BME_OFS_FLAG_CTRL, 8'h00, rd);
        @(posedge clk_i);
        chk(fca, 1'h0);
        wb(1, `BME_OFS_IRQ_STAT, 8'h01, rd);
        wb(0, `BME_OFS_IRQ_STAT, 8'h00, rd);
        chk(rd[0], 1'h0);
        chk(irq_o, 1'h0);
        end_brk;
        sw(1'h1);
        wb(0, `BME_OFS_WAIT_STAT, 8'h00, rd);
        chk(rd, 32'h02);
        wb(1, `BME_OFS_IRQ_MASK, 8'h00, rd);
        @(posedge clk_i);
        chk(irq_o, 1'h0);
        end_brk;
        sw(1'h0);
        wb(0, `BME_OFS_WAIT_STAT, 8'h00, rd);
        chk(rd, 32'h00);
        end_brk;
        hit(a, 1'h0, 1'h0, 1'h0);
        $display("break done");
        // Entry: two corners, then random pins
        for (int i = 0; i < 10; i++) begin
            p = $urandom;
            b = (i == 0) || (i != 1 && p[0]);
            t = !b && (i == 1 || p[1]);
            q = i != 0 && p[2];
            m1 = i == 1 || p[3];
            m2 = i != 1 && p[4];
            h = !b && i != 1 && p[5] && p[6];
            vec <= b ? 16'hffff : (p[7] ? 16'hff12 : 16'h12ff);
            tv <= t;
            irq <= q;
            ms1 <= m1;
            ms2 <= m2;
            hl <= h;
            rstn <= 1'h0;
            repeat (3) @(posedge clk_i);
            rstn <= 1'h1;
            repeat (6) @(posedge clk_i);
            hl <= 1'h0;
            e = exp_mode(b, t, q, m1 && !m2 && !h);
            chk({mode, frc, iosc}, e);
            chk(div, e[0] ? 9'h14f : 9'h100);
            chk(wdog, e[2]);
            ms1 <= !m1;
            ms2 <= !m2;
            repeat (6) @(posedge clk_i);
            chk({mode, frc, iosc}, e);
            sw(1'h0);
            chk(bvec, e[2] ? `BME_VEC_MON : `BME_VEC_USER);
            end_brk;
            if (e[2]) begin
                sec <= 1'h1;
                @(posedge clk_i);
                sec <= 1'h0;
                repeat (2) @(posedge clk_i);
                chk(oe, 1'h1);
                repeat (10 * div + 6) @(posedge clk_i);
                chk(ln >= 10 * div && ln <= 10 * div + 1, 1'h1);
            end
        end
        $display("monitor entry done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire

/* File: src/bme_break_tx.v */
`timescale 1ns/10ps
`default_nettype none

`include "bme_consts.vh"

// Sends a serial break: the line is pulled low for ten bit times.
// Only low is driven; the pull-up makes the high, so both ends share it.
module bme_break_tx (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Control
    input  wire       start_i,
    input  wire [8:0] bit_div_i,
    output reg        busy_o,
    // Serial line, low only
    output wire       line_o,
    output reg        line_oe_o
);

    reg [8:0] div_ff;
    reg [3:0] bits_ff;

    // Output value is always low; the enable decides
    assign line_o = 1'b0;

    // Bit timer and bit counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_ff    <= 9'h000;
            bits_ff   <= 4'h0;
            busy_o    <= 1'b0;
            line_oe_o <= 1'b0;
        end else if (!busy_o) begin
            if (start_i) begin
                busy_o    <= 1'b1;
                line_oe_o <= 1'b1;
                div_ff    <= bit_div_i - 9'h001;
                bits_ff   <= `BME_BREAK_BITS - 4'h1;
            end
        end else if (div_ff != 9'h000) begin
            div_ff <= div_ff - 9'h001;
        end else if (bits_ff != 4'h0) begin
            bits_ff <= bits_ff - 4'h1;
            div_ff  <= bit_div_i - 9'h001;
        end else begin
            // Release after the last bit
            busy_o    <= 1'b0;
            line_oe_o <= 1'b0;
        end
    end

endmodule // bme_break_tx

`default_nettype wire

/* File: src/bme_consts.vh */
`ifndef BME_CONSTS_VH
`define BME_CONSTS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BME_OFS_STAT_CTRL 5'h00
`define BME_OFS_ADDR_HIGH 5'h04
`define BME_OFS_ADDR_LOW  5'h08
`define BME_OFS_AUX       5'h0c
`define BME_OFS_WAIT_STAT 5'h10
`define BME_OFS_FLAG_CTRL 5'h14
`define BME_OFS_IRQ_STAT  5'h18
`define BME_OFS_IRQ_MASK  5'h1c

// ****************************************
// Field positions
// ****************************************
`define BME_BIT_MATCH_EN  7
`define BME_BIT_ACTIVE    6
`define BME_BIT_WDOG_OFF  0
`define BME_BIT_WAIT_EXIT 1
`define BME_BIT_FLAG_CLR  7
`define BME_EV_BREAKPOINT_SIGNAL       0
`define BME_EV_WAIT_EXIT  1
`define BME_EV_MODE       2
`define BME_NUM_EV        3

// ****************************************
// Reset values and codes
// ****************************************
`define BME_RST_BYTE      8'h00
`define BME_ERASED_BYTE   8'hff
`define BME_VEC_USER      16'hfffc
`define BME_VEC_MON       16'hfefc

// ****************************************
// Timing counts (bus clocks per serial bit, bits per break)
// ****************************************
`define BME_DIV_EXT_OSC   9'd256
`define BME_DIV_INT_OSC   9'd335
`define BME_BREAK_BITS    4'd10

`endif

/* File: src/bme_top.v */
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "bme_consts.vh"

module bme_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         irq_o,
    // CPU address bus and core state
    input  wire [15:0] cpu_addr_i,
    input  wire        cpu_addr_vld_i,
    input  wire        cpu_opcode_i,
    input  wire        instr_done_i,
    input  wire        break_end_i,
    input  wire        wait_mode_i,
    input  wire        stop_mode_i,
    // Reset vector bytes as read from flash
    input  wire [7:0]  vec_high_i,
    input  wire [7:0]  vec_low_i,
    // Pins and internal reset (asynchronous)
    input  wire        int_reset_n_i,
    input  wire        test_high_voltage_i,
    input  wire        irq_pin_i,
    input  wire        reset_pin_i,
    input  wire        monitor_serial_pin_i,
    input  wire        mode_select_one_i,
    input  wire        mode_select_two_i,
    // Monitor firmware handshake
    input  wire        security_done_i,
    // Break outputs to the core
    output reg         breakpoint_signal_o,
    output reg  [15:0] break_vector_o,
    output reg         counter_module_halt_o,
    output reg         watchdog_timer_off_o,
    output reg         flag_clear_allow_o,
    // Monitor mode outputs
    output reg         debug_firmware_mode_o,
    output reg         forced_monitor_o,
    output reg         internal_osc_sel_o,
    output reg  [8:0]  baud_div_o,
    // Serial pin drive, low only
    output wire        monitor_serial_pin_o,
    output wire        monitor_serial_pin_oe_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************

    localparam NSYNC = 6;

    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] sync1_ff;
    reg  [NSYNC-1:0] sync2_ff;

    assign pin_raw = {int_reset_n_i, test_high_voltage_i, irq_pin_i,
                      reset_pin_i, monitor_serial_pin_i,
                      {mode_select_one_i}} ;

    // Mode pin two rides in a separate pair below
    reg m2_s1_ff;
    reg m2_s2_ff;

    // Two stages per pin; first stage is read only by the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_i) begin
                if (rst_i) begin
                    // Internal reset loads its idle high, the other pins load zero, so reset shows no false edge
                    sync1_ff[gi] <= (gi == NSYNC-1);
                    sync2_ff[gi] <= (gi == NSYNC-1);
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            m2_s1_ff <= 1'b0;
            m2_s2_ff <= 1'b0;
        end else begin
            m2_s1_ff <= mode_select_two_i;
            m2_s2_ff <= m2_s1_ff;
        end
    end

    wire int_rst_n_s = sync2_ff[5];
    wire test_high_voltage_s      = sync2_ff[4];
    wire irq_s       = sync2_ff[3];
    wire rstpin_s    = sync2_ff[2];
    wire serial_s    = sync2_ff[1];
    wire mode1_s     = sync2_ff[0];
    wire mode2_s     = m2_s2_ff;

    // ****************************************
    // Monitor mode entry latch
    // ****************************************

    reg  int_rst_d_ff;
    wire int_rst_rise = int_rst_n_s & ~int_rst_d_ff;
    wire vec_blank    = (vec_high_i == `BME_ERASED_BYTE) &&
                        (vec_low_i  == `BME_ERASED_BYTE);
    wire normal_entry = test_high_voltage_s & rstpin_s & serial_s &
                        mode1_s & ~mode2_s;
    reg  mode_latch_ev;

    // Captured at the release edge only; later pin changes are ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_rst_d_ff          <= 1'b1;
            debug_firmware_mode_o <= 1'b0;
            forced_monitor_o      <= 1'b0;
            internal_osc_sel_o    <= 1'b0;
            baud_div_o            <= `BME_DIV_EXT_OSC;
            mode_latch_ev         <= 1'b0;
        end else begin
            int_rst_d_ff  <= int_rst_n_s;
            mode_latch_ev <= 1'b0;
            if (int_rst_rise) begin
                mode_latch_ev <= 1'b1;
                if (test_high_voltage_s) begin
                    // Test voltage path works with any vector
                    debug_firmware_mode_o <= normal_entry;
                    forced_monitor_o      <= 1'b0;
                    internal_osc_sel_o    <= 1'b0;
                    baud_div_o            <= `BME_DIV_EXT_OSC;
                end else if (vec_blank) begin
                    // Mode pins play no part here
                    debug_firmware_mode_o <= 1'b1;
                    forced_monitor_o      <= 1'b1;
                    internal_osc_sel_o    <= ~irq_s;
                    baud_div_o <= irq_s ? `BME_DIV_EXT_OSC
                                        : `BME_DIV_INT_OSC;
                end else begin
                    // Programmed vector: user mode only
                    debug_firmware_mode_o <= 1'b0;
                    forced_monitor_o      <= 1'b0;
                    internal_osc_sel_o    <= 1'b0;
                    baud_div_o            <= `BME_DIV_EXT_OSC;
                end
            end
        end
    end

    // ****************************************
    // Register bus decode
    // ****************************************

    reg        match_en_ff;
    reg        active_ff;
    reg  [7:0] addr_high_ff;
    reg  [7:0] addr_low_ff;
    reg        wdog_off_ff;
    reg        wait_exit_ff;
    reg        flag_clr_ff;
    reg  [`BME_NUM_EV-1:0] ev_stat_ff;
    reg  [`BME_NUM_EV-1:0] ev_mask_ff;

    // Writes land on the edge that sees ack high; only lane 0 counts
    wire wr_en  = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    wire wr_sc  = wr_en && (adr_i == `BME_OFS_STAT_CTRL);
    wire wr_ah  = wr_en && (adr_i == `BME_OFS_ADDR_HIGH);
    wire wr_al  = wr_en && (adr_i == `BME_OFS_ADDR_LOW);
    wire wr_aux = wr_en && (adr_i == `BME_OFS_AUX);
    wire wr_fc  = wr_en && (adr_i == `BME_OFS_FLAG_CTRL);
    wire wr_is  = wr_en && (adr_i == `BME_OFS_IRQ_STAT);
    wire wr_im  = wr_en && (adr_i == `BME_OFS_IRQ_MASK);

    reg [7:0] rd_byte;

    // Read mux; unmapped offsets answer zero
    always @* begin
        rd_byte = 8'h00;
        case (adr_i)
            `BME_OFS_STAT_CTRL: begin
                rd_byte[`BME_BIT_MATCH_EN] = match_en_ff;
                rd_byte[`BME_BIT_ACTIVE]   = active_ff;
            end
            `BME_OFS_ADDR_HIGH: rd_byte = addr_high_ff;
            `BME_OFS_ADDR_LOW:  rd_byte = addr_low_ff;
            `BME_OFS_AUX: begin
                rd_byte[`BME_BIT_WDOG_OFF] = wdog_off_ff;
            end
            `BME_OFS_WAIT_STAT: begin
                rd_byte[`BME_BIT_WAIT_EXIT] = wait_exit_ff;
            end
            `BME_OFS_FLAG_CTRL: begin
                rd_byte[`BME_BIT_FLAG_CLR] = flag_clr_ff;
            end
            `BME_OFS_IRQ_STAT: rd_byte[`BME_NUM_EV-1:0] = ev_stat_ff;
            `BME_OFS_IRQ_MASK: rd_byte[`BME_NUM_EV-1:0] = ev_mask_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait state: ack rises the cycle after the request, then drops
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (cyc_i & stb_i & ~ack_o) begin
                dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // ****************************************
    // Break control registers
    // ****************************************

    wire [15:0] brk_addr = {addr_high_ff, addr_low_ff};

    // Static bus in wait/stop would hold a match forever, so the
    // compare is masked there even though the unit stays enabled.
    wire addr_hit = match_en_ff & cpu_addr_vld_i &
                    ~wait_mode_i & ~stop_mode_i &
                    (cpu_addr_i == brk_addr);
    wire sw_force = wr_sc & dat_i[`BME_BIT_ACTIVE];

    always @(posedge clk_i) begin
        if (rst_i) begin
            match_en_ff  <= 1'b0;
            active_ff    <= 1'b0;
            addr_high_ff <= `BME_RST_BYTE;
            addr_low_ff  <= `BME_RST_BYTE;
            wdog_off_ff  <= 1'b0;
            flag_clr_ff  <= 1'b0;
        end else begin
            if (wr_sc) begin
                match_en_ff <= dat_i[`BME_BIT_MATCH_EN];
            end
            // A match in the same cycle as a clear wins
            if (addr_hit) begin
                active_ff <= 1'b1;
            end else if (wr_sc) begin
                active_ff <= dat_i[`BME_BIT_ACTIVE];
            end
            if (wr_ah) begin
                addr_high_ff <= dat_i[7:0];
            end
            if (wr_al) begin
                addr_low_ff <= dat_i[7:0];
            end
            if (wr_aux) begin
                wdog_off_ff <= dat_i[`BME_BIT_WDOG_OFF];
            end
            if (wr_fc) begin
                flag_clr_ff <= dat_i[`BME_BIT_FLAG_CLR];
            end
        end
    end

    // ****************************************
    // Break sequencing
    // ****************************************

    localparam ST_RUN  = 2'b00;
    localparam ST_PEND = 2'b01;
    localparam ST_BRK  = 2'b10;

    reg  [1:0] state_ff;
    reg  [1:0] nxt_state;
    reg        fire;

    // Opcode hits break at once, before the instruction runs; operand
    // hits and software forcing wait for the instruction boundary.
    always @* begin
        nxt_state = state_ff;
        fire      = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (addr_hit & cpu_opcode_i) begin
                    fire      = 1'b1;
                    nxt_state = ST_BRK;
                end else if (addr_hit | sw_force) begin
                    nxt_state = ST_PEND;
                end
            end
            ST_PEND: begin
                if (instr_done_i) begin
                    fire      = 1'b1;
                    nxt_state = ST_BRK;
                end
            end
            ST_BRK: begin
                if (break_end_i) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    wire in_break = (nxt_state == ST_BRK);

    // Core-facing outputs, all registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            breakpoint_signal_o   <= 1'b0;
            break_vector_o        <= `BME_VEC_USER;
            counter_module_halt_o <= 1'b0;
            watchdog_timer_off_o  <= 1'b0;
            flag_clear_allow_o    <= 1'b1;
            wait_exit_ff          <= 1'b0;
        end else begin
            breakpoint_signal_o <= fire;
            break_vector_o <= debug_firmware_mode_o ?
                              `BME_VEC_MON : `BME_VEC_USER;
            counter_module_halt_o <= in_break;
            // Forced or test-voltage entry keeps it off
            watchdog_timer_off_o <=
                (in_break & wdog_off_ff & debug_firmware_mode_o) |
                (debug_firmware_mode_o & forced_monitor_o) |
                (debug_firmware_mode_o & test_high_voltage_s);
            // Outside break, flags always clear normally
            flag_clear_allow_o <= ~in_break | flag_clr_ff;
            if (fire) begin
                wait_exit_ff <= wait_mode_i;
            end
        end
    end

    // ****************************************
    // Event status, mask and interrupt
    // ****************************************

    wire [`BME_NUM_EV-1:0] ev_set;
    assign ev_set[`BME_EV_BREAKPOINT_SIGNAL]      = fire;
    assign ev_set[`BME_EV_WAIT_EXIT] = fire & wait_mode_i;
    assign ev_set[`BME_EV_MODE]      = mode_latch_ev;

    // Write one clears; a new event in the same cycle stays set
    always @(posedge clk_i) begin
        if (rst_i) begin
            ev_stat_ff <= {`BME_NUM_EV{1'b0}};
            ev_mask_ff <= {`BME_NUM_EV{1'b0}};
            irq_o      <= 1'b0;
        end else begin
            ev_stat_ff <= ev_set | (ev_stat_ff &
                          ~(wr_is ? dat_i[`BME_NUM_EV-1:0]
                                  : {`BME_NUM_EV{1'b0}}));
            if (wr_im) begin
                ev_mask_ff <= dat_i[`BME_NUM_EV-1:0];
            end
            irq_o <= |(ev_stat_ff & ev_mask_ff);
        end
    end

    // ****************************************
    // Ready break on the serial pin
    // ****************************************

    reg sec_start_ff;

    // Only meaningful once monitor mode is latched
    always @(posedge clk_i) begin
        if (rst_i) begin
            sec_start_ff <= 1'b0;
        end else begin
            sec_start_ff <= security_done_i &
                            debug_firmware_mode_o;
        end
    end

    bme_break_tx u_break_tx (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (sec_start_ff),
        .bit_div_i (baud_div_o),
        .busy_o    (),
        .line_o    (monitor_serial_pin_o),
        .line_oe_o (monitor_serial_pin_oe_o)
    );

endmodule // bme_top

`default_nettype wire
